// file: rtl/gpi_port.sv
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Functional notes
// - Pin output value and direction come from software data and dir regs.
// - Direction register drives the pad direction output directly.
// - Output data register drives each pad output buffer.
// - External port read returns pin values; writes to it are ignored.
// - Each pin may be high level, low level, rising or falling source.
// - Interrupts are maskable; raw and masked status are both readable.
// - All masked interrupts OR into one output with no own mask.
// - Switching a pin to output keeps its pending interrupt, no new ones.
// - Writing 1 to edge clear clears that edge interrupt, raw and masked.
// - Edge clear writes leave level interrupts; levels follow their source.
// - An unmasked level interrupt keeps requesting while its condition holds.
// - Debounced inputs need two debounce clock samples to be accepted.
// - A pulse over two debounce edges counts; over one edge it is dropped.
// - Edge and level inputs both sync to pclk; the sync bit adds one more pclk stage to levels.
// - Unused addresses and bits read zero; no error response ever.
// - Thirty-two pins, each with own data and direction, 32-bit bus.
// - Direction bit 0 is input and reset value, 1 is output.
// - Type bit 0 is level and reset value, 1 is edge.
// - Polarity bit 0 is low or falling, reset value; 1 high or rising.
// - A pin is an interrupt source only while its enable bit is 1.
module gpi_port #(
  parameter int PINS = gpi_pkg::GPI_PINS,
  parameter int DB_DIV = gpi_pkg::DB_DIV_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpi_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  // Combined interrupt, active high
  output logic irq
);
  import gpi_pkg::*;

  // Software registers
  logic [PINS-1:0] output_data_reg_q, dir_q, int_en_q;
  logic [PINS-1:0] interrupt_mask_reg_q, int_type_q, int_pol_q;
  logic [PINS-1:0] debounce_en_q;
  logic level_sync_enable_q;

  // Bus handshake state
  gpi_apb_e state_q, state_d;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  // Pin synchroniser and derived state
  logic [PINS-1:0] pad_meta_q, pad_sync_q;
  logic [PINS-1:0] raw_status;
  logic [PINS-1:0] int_status;
  logic irq_q;

  // Debounce clock enable
  logic [DB_CNT_W-1:0] db_cnt_q;
  logic db_tick_q;

  // Decode of the access phase
  wire access = psel & penable;
  wire wr_fire = (state_q == APB_ANSWER) & access & pwrite;
  wire hit_data = (paddr == OFS_DATA);
  wire hit_dir = (paddr == OFS_DIR);
  wire hit_en = (paddr == OFS_INT_EN);
  wire hit_mask = (paddr == OFS_MASK);
  wire hit_type = (paddr == OFS_TYPE);
  wire hit_pol = (paddr == OFS_POL);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_raw = (paddr == OFS_RAW);
  wire hit_db = (paddr == OFS_DEBOUNCE);
  wire hit_eoi = (paddr == OFS_EOI);
  wire hit_ext = (paddr == OFS_EXT);
  wire hit_ls = (paddr == OFS_LS_SYNC);

  // Write strobes per register; the external port has none
  wire we_data = wr_fire & hit_data;
  wire we_dir = wr_fire & hit_dir;
  wire we_en = wr_fire & hit_en;
  wire we_mask = wr_fire & hit_mask;
  wire we_type = wr_fire & hit_type;
  wire we_pol = wr_fire & hit_pol;
  wire we_db = wr_fire & hit_db;
  wire we_ls = wr_fire & hit_ls;
  wire [PINS-1:0] eoi_clear = (wr_fire & hit_eoi) ?
                              pwdata[PINS-1:0] : '0;

  // Read mux; unmapped offsets and write-only clear read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RST_WORD;
    if (hit_data) rd_mux[PINS-1:0] = output_data_reg_q;
    if (hit_dir) rd_mux[PINS-1:0] = dir_q;
    if (hit_en) rd_mux[PINS-1:0] = int_en_q;
    if (hit_mask) rd_mux[PINS-1:0] = interrupt_mask_reg_q;
    if (hit_type) rd_mux[PINS-1:0] = int_type_q;
    if (hit_pol) rd_mux[PINS-1:0] = int_pol_q;
    if (hit_status) rd_mux[PINS-1:0] = int_status;
    if (hit_raw) rd_mux[PINS-1:0] = raw_status;
    if (hit_db) rd_mux[PINS-1:0] = debounce_en_q;
    if (hit_ext) rd_mux[PINS-1:0] = pad_sync_q;
    if (hit_ls) rd_mux[LS_SYNC_BIT] = level_sync_enable_q;
  end

  // Slave answers one cycle into the access phase, never in error
  always_comb begin
    state_d = state_q;
    case (state_q)
      APB_IDLE: begin
        if (access) state_d = APB_ANSWER;
      end
      APB_ANSWER: begin
        state_d = APB_IDLE;
      end
      default: begin
        state_d = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= APB_IDLE;
      pready_q <= RST_BIT;
      pslverr_q <= RST_BIT;
      prdata_q <= RST_WORD;
    end else begin
      state_q <= state_d;
      pready_q <= (state_d == APB_ANSWER);
      pslverr_q <= RST_BIT;
      if (state_q == APB_IDLE && access && !pwrite) prdata_q <= rd_mux;
    end
  end

  // Data and direction registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_data_reg_q <= RST_WORD[PINS-1:0];
      dir_q <= RST_WORD[PINS-1:0];
    end else begin
      if (we_data) output_data_reg_q <= pwdata[PINS-1:0];
      if (we_dir) dir_q <= pwdata[PINS-1:0];
    end
  end

  // Interrupt configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_en_q <= RST_WORD[PINS-1:0];
      interrupt_mask_reg_q <= RST_WORD[PINS-1:0];
      int_type_q <= RST_WORD[PINS-1:0];
      int_pol_q <= RST_WORD[PINS-1:0];
    end else begin
      if (we_en) int_en_q <= pwdata[PINS-1:0];
      if (we_mask) interrupt_mask_reg_q <= pwdata[PINS-1:0];
      if (we_type) int_type_q <= pwdata[PINS-1:0];
      if (we_pol) int_pol_q <= pwdata[PINS-1:0];
    end
  end

  // Debounce and level sync enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      debounce_en_q <= RST_WORD[PINS-1:0];
      level_sync_enable_q <= RST_BIT;
    end else begin
      if (we_db) debounce_en_q <= pwdata[PINS-1:0];
      if (we_ls) level_sync_enable_q <= pwdata[LS_SYNC_BIT];
    end
  end

  // Pads see the registers straight from their flops
  assign pad_out = output_data_reg_q;
  assign pad_oe = dir_q;

  // Pins are asynchronous, so two flops come before any reader
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pad_meta_q <= RST_WORD[PINS-1:0];
      pad_sync_q <= RST_WORD[PINS-1:0];
    end else begin
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // Debounce clock as an enable; divide of one ticks every cycle
  wire db_wrap = (db_cnt_q == DB_CNT_W'(DB_DIV - 1));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      db_cnt_q <= '0;
      db_tick_q <= RST_BIT;
    end else begin
      db_cnt_q <= db_wrap ? '0 : db_cnt_q + 1'b1;
      db_tick_q <= db_wrap;
    end
  end

  // One detector per pin
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    gpi_cfg_s cfg;
    assign cfg = '{en: int_en_q[i], dir: dir_q[i], edge_sel: int_type_q[i],
                   pol: int_pol_q[i], db_en: debounce_en_q[i]};
    gpi_pin_irq u_pin (
      .clk(clk),
      .resetn(resetn),
      .db_tick(db_tick_q),
      .ls_sync(level_sync_enable_q),
      .pin_sync(pad_sync_q[i]),
      .cfg(cfg),
      .clear(eoi_clear[i]),
      .raw(raw_status[i])
    );
  end

  // Masking and the combined line; no mask of its own
  assign int_status = raw_status & ~interrupt_mask_reg_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) irq_q <= RST_BIT;
    else irq_q <= |int_status;
  end

  // Every output leaves from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_dir_to_pad: assert property (
    we_dir |=> pad_oe == $past(pwdata[PINS-1:0]))
    else $error("pad direction did not follow the register");
  a_data_to_pad: assert property (
    we_data |=> pad_out == $past(pwdata[PINS-1:0]))
    else $error("pad output did not follow the register");
  a_data_only_wr: assert property (
    !we_data |=> $stable(pad_out))
    else $error("pad output changed without a write");
  a_ext_read: assert property (
    state_q == APB_IDLE && access && !pwrite && hit_ext
    |=> prdata == $past(pad_sync_q))
    else $error("external port read wrong value");
  a_ext_no_write: assert property (
    wr_fire && hit_ext |=> $stable(pad_out) && $stable(pad_oe))
    else $error("write to external port had an effect");
  a_mask_status: assert property (
    int_status == (raw_status & ~interrupt_mask_reg_q))
    else $error("masked status disagrees with raw and mask");
  a_irq_or: assert property (
    ##1 irq == $past(|(raw_status & ~interrupt_mask_reg_q)))
    else $error("combined interrupt is not the OR of status");
  a_irq_all_mask: assert property (
    (&interrupt_mask_reg_q)[*2] |-> !irq)
    else $error("combined interrupt with all pins masked");
  a_eoi_clears: assert property (
    wr_fire && hit_eoi && pwdata[2] && int_type_q[2] &&
    !g_pin[2].u_pin.edge_hit |=> !raw_status[2])
    else $error("edge clear left the raw bit set");
  a_no_error: assert property (
    pready |-> !pslverr)
    else $error("slave signalled an error");
  a_unmapped_zero: assert property (
    state_q == APB_IDLE && access && !pwrite &&
    !(hit_data | hit_dir | hit_en | hit_mask | hit_type | hit_pol |
      hit_status | hit_raw | hit_db | hit_ext | hit_ls)
    |=> prdata == RST_WORD)
    else $error("unmapped read returned non zero");
  a_ready_pulse: assert property (
    access && state_q == APB_IDLE |=> pready ##1 !pready)
    else $error("ready is not a single cycle answer");

  c_edge_irq: cover property (int_type_q[0] && raw_status[0] ##1 irq);
  c_level_irq: cover property (!int_type_q[1] && raw_status[1] ##1 irq);
  c_eoi_write: cover property (wr_fire && hit_eoi && |raw_status);
  c_ext_read: cover property (pready && hit_ext && !pwrite);
endmodule // gpi_port

// file: common/gpi_pkg.sv
package gpi_pkg;
  // Port geometry
  localparam int GPI_PINS = 32;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_DIR = 12'h004;
  localparam logic [11:0] OFS_INT_EN = 12'h030;
  localparam logic [11:0] OFS_MASK = 12'h034;
  localparam logic [11:0] OFS_TYPE = 12'h038;
  localparam logic [11:0] OFS_POL = 12'h03C;
  localparam logic [11:0] OFS_STATUS = 12'h040;
  localparam logic [11:0] OFS_RAW = 12'h044;
  localparam logic [11:0] OFS_DEBOUNCE = 12'h048;
  localparam logic [11:0] OFS_EOI = 12'h04C;
  localparam logic [11:0] OFS_EXT = 12'h050;
  localparam logic [11:0] OFS_LS_SYNC = 12'h060;
  // Values after reset and field positions
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic RST_BIT = 1'h0;
  localparam int LS_SYNC_BIT = 0;
  // Bit encodings
  localparam logic DIR_INPUT = 1'h0;
  localparam logic DIR_OUTPUT = 1'h1;
  localparam logic TYPE_LEVEL = 1'h0;
  localparam logic TYPE_EDGE = 1'h1;
  localparam logic POL_LOW = 1'h0;
  localparam logic POL_HIGH = 1'h1;
  // Debounce clock rate against the 25 MHz system clock
  localparam int CLK_HZ = 25_000_000;
  localparam int DB_CLK_HZ = 25_000_000;
  localparam int DB_DIV_CYC = (CLK_HZ / DB_CLK_HZ < 1) ? 1 :
                              CLK_HZ / DB_CLK_HZ;
  localparam int DB_CNT_W = 8;
  // Slave handshake states
  typedef enum logic {APB_IDLE, APB_ANSWER} gpi_apb_e;
  // Per-pin configuration bundle
  typedef struct packed {
    logic en;
    logic dir;
    logic edge_sel;
    logic pol;
    logic db_en;
  } gpi_cfg_s;
endpackage

// file: rtl/gpi_pin_irq.sv
`timescale 1ns/10ps
module gpi_pin_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Shared controls
  input wire logic db_tick,
  input wire logic ls_sync,
  // Pin sample, configuration and clear
  input wire logic pin_sync,
  input wire gpi_pkg::gpi_cfg_s cfg,
  input wire logic clear,
  // Raw interrupt of this pin
  output logic raw
);
  import gpi_pkg::*;

  logic db_a_q, db_q, prev_q, edge_q, lvl_q;
  logic edge_d, lvl_d;
  wire src = cfg.db_en ? db_q : pin_sync;
  wire lvl_src = ls_sync ? prev_q : src; // Extra pclk stage when asked
  wire listening = cfg.en & (cfg.dir == DIR_INPUT);
  wire rise = src & ~prev_q;
  wire fall = ~src & prev_q;
  wire edge_hit = listening & (cfg.edge_sel == TYPE_EDGE) &
                  ((cfg.pol == POL_HIGH) ? rise : fall);

  // Debouncer: a value is taken only when two ticks agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      db_a_q <= RST_BIT;
      db_q <= RST_BIT;
    end else if (db_tick) begin
      db_a_q <= pin_sync;
      if (pin_sync == db_a_q) db_q <= pin_sync;
    end
  end

  // Set wins over clear so an edge in the clear cycle survives
  always_comb begin
    edge_d = edge_q;
    if (edge_hit) edge_d = 1'b1;
    else if (clear | ~cfg.en | (cfg.edge_sel == TYPE_LEVEL))
      edge_d = 1'b0;
  end

  // Level state is frozen while the pin is an output
  assign lvl_d = cfg.en & (cfg.edge_sel == TYPE_LEVEL) &
                 ((cfg.dir == DIR_OUTPUT) ? lvl_q :
                  (lvl_src == cfg.pol));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= RST_BIT;
      edge_q <= RST_BIT;
      lvl_q <= RST_BIT;
    end else begin
      prev_q <= src;
      edge_q <= edge_d;
      lvl_q <= lvl_d;
    end
  end

  assign raw = edge_q | lvl_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_out_no_new: assert property (
    (cfg.dir == DIR_OUTPUT) && !edge_q && $stable(cfg) |=> !edge_q)
    else $error("edge interrupt raised on an output pin");
  a_clear_edge: assert property (
    clear && !edge_hit && cfg.edge_sel |=> !edge_q)
    else $error("edge clear did not clear the pin");
  a_level_hold: assert property (
    lvl_q && clear && $stable(cfg) && cfg.en && !cfg.dir &&
    (lvl_src == cfg.pol) |=> lvl_q)
    else $error("edge clear disturbed a level interrupt");
  a_db_reject: assert property (
    db_tick && (pin_sync != db_a_q) |=> $stable(db_q))
    else $error("debouncer took a one tick pulse");
  c_edge_set: cover property (edge_hit ##1 edge_q);
endmodule // gpi_pin_irq

// file: tb/gpi_pad_model.sv
`timescale 1ns/10ps
// Far-side pad ring: each pad either carries the port's own output or
// whatever the outside world drives, so a pad read always sees a real level
module gpi_pad_model #(
  parameter int PINS = 32
) (
  // Port side
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  // Outside world and resolved level
  input wire logic [PINS-1:0] ext_drv,
  output logic [PINS-1:0] pad_in
);
  // A driven pad shows the port's value, an input pad the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv);
endmodule // gpi_pad_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import gpi_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] pad_in;
  logic [31:0] pad_out;
  logic [31:0] pad_oe;
  logic [31:0] ext_drv = '0;
  logic irq;
  int error_cnt = 0;
  int n_checks = 0;
  logic [11:0] rst_ofs [12] = '{OFS_DATA, OFS_DIR, OFS_INT_EN, OFS_MASK,
    OFS_TYPE, OFS_POL, OFS_STATUS, OFS_RAW, OFS_DEBOUNCE, OFS_EOI,
    OFS_LS_SYNC, 12'h010};

  // 25 MHz system clock
  always #20 clk = ~clk;

  gpi_port #(.PINS(32), .DB_DIV(1)) DUT (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq)
  );

  gpi_pad_model #(.PINS(32)) pads (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_drv(ext_drv), .pad_in(pad_in)
  );

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the rising edge where pready
  // is high, before the slave's flops move, and only then released
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // A hung slave is ended by the watchdog, not here
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    // Let one edge pass so the next setup never overwrites this release
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    idle(20000);
    error_cnt++;
    close_out();
  end

  initial begin
    idle(4);
    resetn <= 1'b1;
    idle(1);
    // Reset state of pad direction, interrupt and every register but the external port, plus a hole
    chk(pad_oe, 32'h0);
    chk({31'h0, irq}, 32'h0);
    foreach (rst_ofs[i]) rd(rst_ofs[i], 32'h0);
    // Data and direction reach the pads and read back
    wr(OFS_DATA, 32'hA5A55A5A);
    wr(OFS_DIR, 32'hFFFF0000);
    ext_drv <= 32'h5555C30A;
    rd(OFS_DATA, 32'hA5A55A5A);
    rd(OFS_DIR, 32'hFFFF0000);
    chk(pad_out, 32'hA5A55A5A);
    chk(pad_oe, 32'hFFFF0000);
    // Pin readback, writes to it ignored, unused bits zero
    rd(OFS_EXT, 32'hA5A5C30A);
    wr(OFS_EXT, 32'hFFFFFFFF);
    rd(OFS_EXT, 32'hA5A5C30A);
    wr(OFS_LS_SYNC, 32'hFFFFFFFF);
    rd(OFS_LS_SYNC, 32'h1);
    // Pins 0..3: high level, low level, rising, falling; 4,5 rising
    wr(OFS_TYPE, 32'h3C);
    wr(OFS_POL, 32'h35);
    wr(OFS_DEBOUNCE, 32'h10);
    rd(OFS_POL, 32'h35);
    ext_drv[3:0] <= 4'h5;
    idle(8);
    rd(OFS_RAW, 32'h0);
    ext_drv[3:0] <= 4'hA;
    idle(8);
    wr(OFS_INT_EN, 32'h3F);
    ext_drv[3:0] <= 4'h5;
    idle(8);
    rd(OFS_RAW, 32'hF);
    rd(OFS_STATUS, 32'hF);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_MASK, 32'h3);
    rd(OFS_STATUS, 32'hC);
    rd(OFS_RAW, 32'hF);
    wr(OFS_EOI, 32'hF);
    rd(OFS_RAW, 32'h3);
    rd(OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0);
    idle(4);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_STATUS, 32'h3);
    // Combined line goes quiet once every pin is masked
    wr(OFS_MASK, 32'hFFFFFFFF);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_RAW, 32'h3);
    wr(OFS_MASK, 32'h0);
    ext_drv[3:0] <= 4'hA;
    idle(8);
    rd(OFS_RAW, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Pending edge survives a switch to output; no new edge as output
    ext_drv[2] <= 1'b1;
    idle(8);
    rd(OFS_RAW, 32'h4);
    wr(OFS_DIR, 32'hFFFF0004);
    idle(8);
    rd(OFS_RAW, 32'h4);
    wr(OFS_EOI, 32'h4);
    wr(OFS_DATA, 32'hA5A55A5E);
    idle(8);
    chk(pad_out, 32'hA5A55A5E);
    rd(OFS_RAW, 32'h0);
    wr(OFS_DIR, 32'hFFFF0000);
    idle(4);
    // One-cycle glitch: kept on plain pin 5, dropped on debounced pin 4
    ext_drv[5:4] <= 2'b11;
    idle(1);
    ext_drv[5:4] <= 2'b00;
    idle(8);
    rd(OFS_RAW, 32'h20);
    wr(OFS_EOI, 32'h20);
    // Two-cycle pulse spans two ticks and is accepted when debounced
    ext_drv[4] <= 1'b1;
    idle(2);
    ext_drv[4] <= 1'b0;
    idle(8);
    rd(OFS_RAW, 32'h10);
    close_out();
  end
endmodule // tb_top
